// >>> scs_cfg.svh
`ifndef SCS_CFG_SVH
`define SCS_CFG_SVH

// clock period in ps (200 MHz)
`define SCS_CLK_PS          5000
// longest conversion time, ns
`define SCS_TCONV_NS        392
// cycles: longest time rounds down
`define SCS_CONV_CYC        ((`SCS_TCONV_NS * 1000) / `SCS_CLK_PS)
// least acquisition time, ns
`define SCS_TACQ_NS         95
`define SCS_ACQ_CYC         (((`SCS_TACQ_NS * 1000) + `SCS_CLK_PS - 1) / `SCS_CLK_PS)
// settle window after start in which the start line may toggle, ns
`define SCS_TQUIET_NS       40
`define SCS_QUIET_CYC       (((`SCS_TQUIET_NS * 1000) + `SCS_CLK_PS - 1) / `SCS_CLK_PS)
// wait after power-on reset, us
`define SCS_TPOR_US         200
`define SCS_POR_CYC         ((`SCS_TPOR_US * 1000000) / `SCS_CLK_PS)
// serial clock rising edges that clear the io register
`define SCS_CLR_EDGES       20
// result width
`define SCS_RES_W           24
// serial clock half period in host clocks
`define SCS_SCK_HALF        4

`endif

// >>> scs_pkg.sv
package scs_pkg;
	typedef enum {SCS_D_IDLE, SCS_D_CONV} scs_dev_state_t;
	typedef enum {SCS_H_POR, SCS_H_CLR, SCS_H_START, SCS_H_WAIT, SCS_H_READ, SCS_H_ACQ}
		scs_host_state_t;
endpackage : scs_pkg

// >>> scs_link_if.sv
`timescale 1ns/10ps
interface scs_link_if;
	logic convert_start;
	logic sck;
	logic busy;
	logic sdo;
	modport dev  (input convert_start, input sck, output busy, output sdo);
	modport host (output convert_start, output sck, input busy, input sdo);
endinterface : scs_link_if

// >>> scs_device.sv
`timescale 1ns/10ps
`include "scs_cfg.svh"
// Contract
// - start-line rising edge starts conversion, powers up
// - no restart while conversion runs
// - busy high for whole conversion
// - host toggles start only early or after
// - internal clock times conversion, 392ns max
// - host allows 95ns acquisition between conversions
// - single reads limit output rate 1.5Msps
// - power down and acquire after completion
// - last result readable while powered down
// - host stops serial clock during conversion
// - power-on reset reinitialises the device
// - host waits 200us after power-on reset
// - host clears io registers after reset
// - host clears io after reference recovery (no reference recovery is modelled here)
// - 20 serial edges before start clear io (here only before the first start after reset)
// - serial interface steers averaging filter (here the filter is a pass-through and reading_ff steers nothing)
// - 1..19 edges between busy falls hold output
// - 24-bit result captured at start edge
module scs_device
	import scs_pkg::*;
#(
	parameter int RES_W = `SCS_RES_W
)(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// link
	scs_link_if.dev               lnk,
	// analog sample and status
	input  wire logic [RES_W-1:0] sample_in,
	output logic                  powered_up,
	output logic [RES_W-1:0]      io_reg
);
	localparam logic [8:0] CONV_CYC = 9'(`SCS_CONV_CYC);
	localparam logic [5:0] CLR_N    = 6'(`SCS_CLR_EDGES);

	// -----------------------------------------------------------------
	// pin synchronisers
	// -----------------------------------------------------------------
	// both link inputs come from another clock: two flops each, and the
	// edge register reads only the second stage, so no metastable value
	// ever reaches the edge detectors
	// idle level of both pins is low, so reset values of zero give no
	// false edge straight after reset
	logic [1:0] cnv_sync_ff;
	logic [1:0] sck_sync_ff;
	logic       cnv_d_ff;
	logic       sck_d_ff;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnv_sync_ff <= 2'h0;
			sck_sync_ff <= 2'h0;
			cnv_d_ff    <= 1'b0;
			sck_d_ff    <= 1'b0;
		end
		else
		begin
			cnv_sync_ff <= {cnv_sync_ff[0], lnk.convert_start};
			sck_sync_ff <= {sck_sync_ff[0], lnk.sck};
			cnv_d_ff    <= cnv_sync_ff[1];
			sck_d_ff    <= sck_sync_ff[1];
		end
	end
	wire cnv_rise = cnv_sync_ff[1] & ~cnv_d_ff;
	wire sck_rise = sck_sync_ff[1] & ~sck_d_ff;

	// -----------------------------------------------------------------
	// conversion sequencer
	// -----------------------------------------------------------------
	scs_dev_state_t    state_ff;
	logic [8:0]        cnt_ff;
	logic [RES_W-1:0]  result_ff;
	logic              seen_start_ff;
	logic [5:0]        sck_cnt_ff;
	logic              reading_ff;
	logic [RES_W-1:0]  acc_ff;
	logic [RES_W-1:0]  shift_ff;
	logic              sdo_ff;

	wire start_ok  = (state_ff == SCS_D_IDLE) && cnv_rise;
	wire conv_done = (state_ff == SCS_D_CONV) && (cnt_ff == CONV_CYC - 9'h1);
	wire clr_hit   = !seen_start_ff && sck_rise && (sck_cnt_ff >= CLR_N - 6'h1);
	// a read is open once at least one but fewer than the clear count of edges arrived
	wire hold_io   = (sck_cnt_ff != 6'h0) && (sck_cnt_ff < CLR_N);

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_ff <= SCS_D_IDLE;
			cnt_ff   <= 9'h0;
		end
		else
		begin
			case (state_ff)
				SCS_D_IDLE:
				begin
					cnt_ff <= 9'h0;
					if (start_ok)
						state_ff <= SCS_D_CONV;
				end
				SCS_D_CONV:
				begin
					cnt_ff <= cnt_ff + 9'h1;
					if (conv_done)
						state_ff <= SCS_D_IDLE;
				end
				default:
					state_ff <= SCS_D_IDLE;
			endcase
		end
	end

	assign lnk.busy   = (state_ff == SCS_D_CONV);
	assign powered_up = (state_ff == SCS_D_CONV);

	// -----------------------------------------------------------------
	// result, filter and io register
	// -----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			result_ff     <= '0;
			seen_start_ff <= 1'b0;
		end
		else if (start_ok)
		begin
			result_ff     <= sample_in;
			seen_start_ff <= 1'b1;
		end
	end

	// serial edge count between busy falls; restarts on each completion
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			sck_cnt_ff <= 6'h0;
		else if (conv_done)
			sck_cnt_ff <= 6'h0;
		else if (sck_rise && sck_cnt_ff != 6'h3F)
			sck_cnt_ff <= sck_cnt_ff + 6'h1;
	end

	// -----------------------------------------------------------------
	// averaging filter stand-in
	// -----------------------------------------------------------------
	// limitation: pass-through of the latest result, no averaging and no
	// scaling, so a distributed read returns the last result, not a mean
	// the filter output follows the result register every cycle, so it is
	// already settled when a completion copies it into the io register
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			acc_ff     <= '0;
			reading_ff <= 1'b0;
		end
		else
		begin
			if (sck_rise && !reading_ff)
				reading_ff <= 1'b1;
			else if (conv_done && !hold_io)
				reading_ff <= 1'b0;
			acc_ff <= result_ff;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			io_reg   <= '0;
			shift_ff <= '0;
			sdo_ff   <= 1'b0;
		end
		else if (clr_hit)
		begin
			io_reg   <= '0;
			shift_ff <= '0;
			sdo_ff   <= 1'b0;
		end
		// a completion with 1..19 serial edges since the last one keeps
		// the io register, so a read may span several conversions
		else if (conv_done && !hold_io)
		begin
			io_reg   <= acc_ff;
			shift_ff <= acc_ff;
			sdo_ff   <= acc_ff[RES_W-1];
		end
		else if (sck_rise)
		begin
			// shifting works in idle too, so the last result stays readable
			shift_ff <= {shift_ff[RES_W-2:0], 1'b0};
			sdo_ff   <= shift_ff[RES_W-2];
		end
	end
	assign lnk.sdo = sdo_ff;
endmodule : scs_device

// >>> scs_host.sv
`timescale 1ns/10ps
`include "scs_cfg.svh"
module scs_host
	import scs_pkg::*;
#(
	parameter int POR_CYC = `SCS_POR_CYC,
	parameter int RES_W   = `SCS_RES_W,
	parameter int DEPTH   = 2
)(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// link
	scs_link_if.host              lnk,
	// result stream
	output logic                  res_valid,
	input  wire logic             res_ready,
	output logic [RES_W-1:0]      res_data
);
	localparam logic [7:0] ACQ_CYC   = 8'(`SCS_ACQ_CYC);
	localparam logic [5:0] CLR_N     = 6'(`SCS_CLR_EDGES);
	localparam logic [3:0] HALF      = 4'(`SCS_SCK_HALF);
	localparam logic [7:0] QUIET_CYC = 8'(`SCS_QUIET_CYC);

	// -----------------------------------------------------------------
	// sync of device pins
	// -----------------------------------------------------------------
	logic [1:0] busy_s_ff;
	logic [1:0] sdo_s_ff;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			busy_s_ff <= 2'h0;
			sdo_s_ff  <= 2'h0;
		end
		else
		begin
			busy_s_ff <= {busy_s_ff[0], lnk.busy};
			sdo_s_ff  <= {sdo_s_ff[0], lnk.sdo};
		end
	end

	// -----------------------------------------------------------------
	// two-entry buffer
	// -----------------------------------------------------------------
	logic [RES_W-1:0] mem [DEPTH];
	logic [1:0]       cnt_ff;
	logic             wp_ff;
	logic             rp_ff;
	logic             in_valid;
	logic [RES_W-1:0] word_ff;
	wire in_ready = (cnt_ff != 2'(DEPTH));
	wire push     = in_valid && in_ready;
	wire pop      = res_valid && res_ready;
	assign res_valid = (cnt_ff != 2'h0);
	assign res_data  = mem[rp_ff];
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_ff <= 2'h0;
			wp_ff  <= 1'b0;
			rp_ff  <= 1'b0;
		end
		else
		begin
			if (push)
				wp_ff <= ~wp_ff;
			if (pop)
				rp_ff <= ~rp_ff;
			cnt_ff <= cnt_ff + 2'(push) - 2'(pop);
		end
	end
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wp_ff] <= word_ff;
	end

	// -----------------------------------------------------------------
	// sequencer
	// -----------------------------------------------------------------
	scs_host_state_t st_ff;
	logic [31:0]     tmr_ff;
	logic [5:0]      bits_ff;
	logic [3:0]      div_ff;
	logic            sck_ff;
	logic            cnv_ff;
	wire             tick = (div_ff == HALF - 4'h1);
	assign in_valid     = (st_ff == SCS_H_ACQ) && (tmr_ff == 32'h0) && (bits_ff == 6'h0);
	assign lnk.sck      = sck_ff;
	assign lnk.convert_start = cnv_ff;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_ff   <= SCS_H_POR;
			tmr_ff  <= 32'h0;
			bits_ff <= 6'h0;
			div_ff  <= 4'h0;
			sck_ff  <= 1'b0;
			cnv_ff  <= 1'b0;
			word_ff <= '0;
		end
		else
		begin
			div_ff <= tick ? 4'h0 : div_ff + 4'h1;
			case (st_ff)
				SCS_H_POR:
				begin
					tmr_ff <= tmr_ff + 32'h1;
					if (tmr_ff == 32'(POR_CYC))
					begin
						st_ff   <= SCS_H_CLR;
						bits_ff <= CLR_N;
					end
				end
				SCS_H_CLR:
				begin
					if (tick)
					begin
						sck_ff <= ~sck_ff;
						if (sck_ff)
							bits_ff <= bits_ff - 6'h1;
						if (sck_ff && bits_ff == 6'h1)
							st_ff <= SCS_H_START;
					end
				end
				SCS_H_START:
				begin
					cnv_ff <= 1'b1;
					tmr_ff <= {24'h0, QUIET_CYC};
					st_ff  <= SCS_H_WAIT;
				end
				SCS_H_WAIT:
				begin
					// start line held steady until conversion ends
					if (tmr_ff != 32'h0)
						tmr_ff <= tmr_ff - 32'h1;
					else if (busy_s_ff[1] == 1'b0)
					begin
						cnv_ff  <= 1'b0;
						bits_ff <= 6'(RES_W);
						st_ff   <= SCS_H_READ;
					end
				end
				SCS_H_READ:
				begin
					// one full read per conversion keeps rate legal
					if (tick)
					begin
						sck_ff <= ~sck_ff;
						if (!sck_ff)
							word_ff <= {word_ff[RES_W-2:0], sdo_s_ff[1]};
						else
							bits_ff <= bits_ff - 6'h1;
						if (sck_ff && bits_ff == 6'h1)
						begin
							st_ff  <= SCS_H_ACQ;
							tmr_ff <= {24'h0, ACQ_CYC};
						end
					end
				end
				SCS_H_ACQ:
				begin
					sck_ff <= 1'b0;
					if (tmr_ff != 32'h0)
						tmr_ff <= tmr_ff - 32'h1;
					else if (push)
						st_ff <= SCS_H_START;
				end
				default:
					st_ff <= SCS_H_POR;
			endcase
		end
	end
endmodule : scs_host

// >>> scs_link_props.sv
`timescale 1ns/10ps
`include "scs_cfg.svh"
module scs_link_props #(
	parameter int POR_CYC = 10
)(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// link
	input wire logic convert_start,
	input wire logic sck,
	input wire logic busy,
	input wire logic sdo
);
	localparam int CONV = `SCS_CONV_CYC;
	localparam int ACQ  = `SCS_ACQ_CYC;
	// ------
	// counters
	// ------
	logic [7:0]  hi_ff;
	logic [7:0]  lo_ff;
	logic [5:0]  edg_ff;
	logic [15:0] up_ff;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			hi_ff  <= 8'h00;
			lo_ff  <= 8'h00;
			edg_ff <= 6'h00;
			up_ff  <= 16'h0000;
		end
		else
		begin
			hi_ff  <= busy ? hi_ff + 8'h01 : 8'h00;
			lo_ff  <= busy ? 8'h00 : lo_ff + {7'h00, ~&lo_ff};
			edg_ff <= edg_ff + {5'h00, $rose(sck) && ~&edg_ff};
			up_ff  <= up_ff + {15'h0000, ~&up_ff};
		end
	end
	// ------
	// checks
	// ------
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence busy_up_s;
		##[1:5] $rose(busy);
	endsequence
	sequence quiet_s;
		!busy[*8];
	endsequence
	start_busy_a: assert property ($rose(convert_start) && !busy |-> busy_up_s)
		else $error("busy did not follow start");
	busy_len_a: assert property ($fell(busy) |-> hi_ff == CONV)
		else $error("conversion length wrong");
	busy_cap_a: assert property (busy |-> hi_ff < CONV)
		else $error("conversion overran");
	start_quiet_a: assert property (busy && hi_ff > 8'h08 |-> $stable(convert_start))
		else $error("start toggled late");
	acq_gap_a: assert property ($rose(convert_start) |-> lo_ff >= ACQ)
		else $error("acquisition too short");
	idle_after_a: assert property ($fell(busy) |-> quiet_s)
		else $error("busy back too soon");
	sdo_hold_a: assert property (busy && $past(busy) |-> $stable(sdo))
		else $error("data moved in conversion");
	por_wait_a: assert property ($rose(convert_start) |-> up_ff > POR_CYC)
		else $error("start too early");
	clear_first_a: assert property ($rose(convert_start) |-> edg_ff >= 6'h14)
		else $error("clear pulses missing");
endmodule : scs_link_props

// >>> testbench.sv
`timescale 1ns/10ps
`include "scs_cfg.svh"
module testbench;
	localparam int W    = `SCS_RES_W;
	localparam int CONV = `SCS_CONV_CYC;
	// ------
	// wiring
	// ------
	logic         clk        = 1'b0;
	logic         nrst       = 1'b0;
	logic         res_ready  = 1'b0;
	logic         stall      = 1'b1;
	logic         busy_d     = 1'b0;
	logic [W-1:0] sample_in  = 24'h000000;
	logic [W-1:0] sample_b   = 24'h000000;
	logic [W-1:0] v[4];
	logic [W-1:0] exp_q[$];
	logic [W-1:0] res_data;
	logic [W-1:0] io_b;
	logic         res_valid;
	logic         pwr;
	int           n_mismatch = 0;
	int           n_compared = 0;
	int           n_words    = 0;
	scs_link_if lnk ();
	scs_link_if lnk_b ();
	always #2.5 clk = ~clk;
	scs_device u_scs_device (.clk(clk), .nrst(nrst), .lnk(lnk.dev),
		.sample_in(sample_in), .powered_up(pwr), .io_reg());
	scs_host #(.POR_CYC(10)) u_scs_host (.clk(clk), .nrst(nrst), .lnk(lnk.host),
		.res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
	// second device faces the bench, which breaks host rules on purpose
	scs_device u_scs_device_b (.clk(clk), .nrst(nrst), .lnk(lnk_b.dev),
		.sample_in(sample_b), .powered_up(), .io_reg(io_b));
	scs_link_props #(.POR_CYC(10)) u_scs_link_props (.clk(clk), .nrst(nrst),
		.convert_start(lnk.convert_start), .sck(lnk.sck), .busy(lnk.busy), .sdo(lnk.sdo));
	// ------
	// helpers
	// ------
	function automatic logic [W-1:0] exp_of(input logic [W-1:0] s);
		return s;
	endfunction : exp_of
	task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic pulse_b(input int k);
		repeat (k)
		begin
			lnk_b.sck <= 1'b1;
			repeat (12) @(posedge clk);
			lnk_b.sck <= 1'b0;
			repeat (13) @(posedge clk);
		end
	endtask : pulse_b
	task automatic conv_b(input logic [W-1:0] s);
		int n;
		n = 0;
		sample_b <= s;
		for (int i = 0; i < 150; i++)
		begin
			// second rise sits deep in the conversion
			lnk_b.convert_start <= (i < 6) || (i >= 40 && i < 46);
			@(posedge clk);
			n += int'(lnk_b.busy === 1'b1);
		end
		chk(W'(n), W'(CONV));
	endtask : conv_b
	task automatic results();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	// ------
	// stream monitor
	// ------
	always @(posedge clk)
	begin
		busy_d <= lnk.busy;
		if (busy_d === 1'b1 && lnk.busy === 1'b0)
		begin
			exp_q.push_back(exp_of(sample_in));
			sample_in <= W'($urandom);
			chk(W'(pwr), 24'h000000);
		end
		if (res_valid === 1'b1 && res_ready)
		begin
			chk(res_data, exp_q.pop_front());
			n_words++;
		end
		res_ready <= !stall && ($urandom % 4 != 0);
	end
	initial
	begin
		void'($urandom(22));
		lnk_b.convert_start = 1'b0;
		lnk_b.sck           = 1'b0;
		foreach (v[i])
			v[i] = W'($urandom);
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (20) @(posedge clk);
		pulse_b(20);
		chk(io_b, 24'h000000);
		conv_b(v[0]);
		chk(io_b, v[0]);
		pulse_b(5);
		conv_b(v[1]);
		chk(io_b, v[0]);
		conv_b(v[2]);
		chk(io_b, v[2]);
		pulse_b(20);
		conv_b(v[3]);
		chk(W'(lnk_b.sdo), W'(v[3][W-1]));
		pulse_b(1);
		chk(W'(lnk_b.sdo), W'(v[3][W-2]));
		stall <= 1'b0;
		for (int i = 0; i < 8000 && n_words < 12; i++)
			@(posedge clk);
		if (n_words < 12)
		begin
			n_mismatch++;
			$display("Error at %0t: stream stalled", $time);
		end
		results();
	end
endmodule : testbench
